// *** see_host.sv ***
`timescale 1ns/1ps
module see_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  logic         clock,
    input  logic         sys_rst,
    input  logic         in_valid,
    output logic         in_ready,
    input  logic [W-1:0] in_data,
    output logic         out_valid,
    input  logic         out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem [D];
    logic [PW-1:0] wp_ff;
    logic [PW-1:0] rp_ff;
    logic [CW-1:0] cnt_ff;
    logic          push;
    logic          pop;

    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        step = (p == PW'(D - 1)) ? '0 : p + 1'b1;
    endfunction : step

    assign in_ready  = (cnt_ff != CW'(D));
    assign out_valid = (cnt_ff != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rp_ff];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) wp_ff <= step(wp_ff);
            if (pop) rp_ff <= step(rp_ff);
            cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
        end
    end
endmodule : see_fifo

module see_host
    import see_pkg::*;
#(
    parameter int AW  = ADDR_W,
    parameter int QTR = QTR_CYC,
    parameter int FD  = FIFO_DEPTH
) (
    input  logic          clock,
    input  logic          sys_rst,
    see_link_if.host      lnk,
    input  logic          req_valid,
    output logic          req_ready,
    input  logic          req_read,
    input  logic [AW-1:0] req_addr,
    input  logic [7:0]    req_len,
    input  logic [7:0]    req_wdata,
    output logic          done,
    output logic          nack_err,
    output logic          rd_valid,
    input  logic          rd_ready,
    output logic [7:0]    rd_data
);
    localparam int DW = $clog2(QTR + 1);

    see_hst_e      st_ff;
    logic [DW-1:0] div_ff;
    logic [1:0]    q_ff;
    logic [3:0]    bc_ff;
    logic [7:0]    tx_ff;
    logic [7:0]    rx_ff;
    logic [1:0]    stage_ff;
    logic [7:0]    left_ff;
    logic          rd_ff;
    logic [AW-1:0] addr_ff;
    logic [7:0]    wdata_ff;
    logic          scl_ff;
    logic          oe_ff;
    logic          sda_s1_ff;
    logic          sda_s2_ff;
    logic          done_ff;
    logic          err_ff;

    logic          div_end;
    logic          ack_slot;
    logic          f_ready;
    logic          stall;
    logic          tick;
    logic          in_ack;
    logic [7:0]    dev_byte;

    assign div_end  = (div_ff == DW'(QTR - 1));
    assign in_ack   = (bc_ff == BC_ACK);
    assign ack_slot = (st_ff == H_RBYTE) & in_ack & (q_ff == Q_SET);
    assign stall    = ack_slot & ~f_ready;
    assign tick     = div_end & ~stall;
    assign dev_byte = {DEV_TYPE, 3'(addr_ff >> 8), stage_ff == S_DEVR};
    assign req_ready = (st_ff == H_IDLE);

    see_fifo #(.W(8), .D(FD)) i_see_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (ack_slot & div_end),
        .in_ready  (f_ready),
        .in_data   (rx_ff),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_ff <= H_IDLE;
            div_ff <= '0;
            q_ff <= Q_SET;
            bc_ff <= 4'h0;
            tx_ff <= 8'h00;
            rx_ff <= 8'h00;
            stage_ff <= S_DEVW;
            left_ff <= 8'h00;
            rd_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= 8'h00;
            scl_ff <= 1'b1;
            oe_ff <= 1'b0;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            sda_s1_ff <= lnk.sda;
            sda_s2_ff <= sda_s1_ff;
            done_ff <= 1'b0;
            div_ff <= (div_end || st_ff == H_IDLE) ? (stall ? div_ff : '0) : div_ff + 1'b1;
            if (st_ff == H_IDLE) begin
                q_ff <= Q_SET;
                if (req_valid) begin
                    st_ff <= H_START;
                    stage_ff <= S_DEVW;
                    rd_ff <= req_read;
                    addr_ff <= req_addr;
                    wdata_ff <= req_wdata;
                    left_ff <= req_len;
                    err_ff <= 1'b0;
                end
            end else if (tick) begin
                q_ff <= q_ff + 1'b1;
                if (q_ff == Q_RISE) scl_ff <= 1'b1;
                if (q_ff == Q_FALL && st_ff != H_STOP) scl_ff <= 1'b0;
                unique case (st_ff)
                    H_START: begin
                        if (q_ff == Q_SET) oe_ff <= 1'b0;
                        if (q_ff == Q_MID) oe_ff <= 1'b1;
                        if (q_ff == Q_FALL) begin
                            st_ff <= H_WBYTE;
                            bc_ff <= 4'h0;
                            tx_ff <= dev_byte;
                        end
                    end
                    H_WBYTE: begin
                        if (q_ff == Q_SET) oe_ff <= ~in_ack & ~tx_ff[~bc_ff[2:0]];
                        if (q_ff == Q_MID && in_ack) err_ff <= sda_s2_ff;
                        if (q_ff == Q_FALL) begin
                            bc_ff <= in_ack ? 4'h0 : bc_ff + 1'b1;
                            if (in_ack && err_ff) begin
                                st_ff <= H_STOP;
                            end else if (in_ack) begin
                                stage_ff <= stage_ff + 1'b1;
                                if (stage_ff == S_DEVW) begin
                                    tx_ff <= addr_ff[7:0];
                                end else if (stage_ff == S_WORD && rd_ff) begin
                                    stage_ff <= S_DEVR;
                                    st_ff <= H_START;
                                end else if (stage_ff == S_WORD) begin
                                    tx_ff <= wdata_ff;
                                end else if (stage_ff == S_DATA) begin
                                    st_ff <= H_STOP;
                                end else begin
                                    st_ff <= H_RBYTE;
                                end
                            end
                        end
                    end
                    H_RBYTE: begin
                        if (q_ff == Q_SET) oe_ff <= in_ack & (left_ff > 8'h01);
                        if (q_ff == Q_MID && !in_ack) rx_ff <= {rx_ff[6:0], sda_s2_ff};
                        if (q_ff == Q_FALL) begin
                            bc_ff <= in_ack ? 4'h0 : bc_ff + 1'b1;
                            if (in_ack) left_ff <= left_ff - 1'b1;
                            if (in_ack && left_ff <= 8'h01) st_ff <= H_STOP;
                        end
                    end
                    H_STOP: begin
                        if (q_ff == Q_SET) oe_ff <= 1'b1;
                        if (q_ff == Q_MID) oe_ff <= 1'b0;
                        if (q_ff == Q_FALL) begin
                            st_ff <= H_IDLE;
                            done_ff <= 1'b1;
                        end
                    end
                    default: st_ff <= H_IDLE;
                endcase
            end
        end
    end

    assign lnk.scl         = scl_ff;
    assign lnk.sda_host_o  = 1'b0;
    assign lnk.sda_host_oe = oe_ff;
    assign done            = done_ff;
    assign nack_err        = done_ff & err_ff;
endmodule : see_host

// *** see_pkg.sv ***
package see_pkg;
    // ==========================================================
    // geometry and identity
    localparam int         ADDR_W     = 11;
    localparam int         PAGE_BITS  = 3;
    localparam int         PAGE_LSB_W = 4;
    localparam logic [3:0] DEV_TYPE   = 4'h5; // arbitrary value
    localparam logic [3:0] BC_LAST    = 4'h7;
    localparam logic [3:0] BC_ACK     = 4'h8;
    // ==========================================================
    // timing
    localparam int CLK_MHZ   = 100;
    localparam int SCL_KHZ   = 1000;
    localparam int QTR_CYC   = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
    localparam int TWR_MS    = 3;
    localparam int TWR_CYC   = TWR_MS * CLK_MHZ * 1000;
    localparam int FIFO_DEPTH = 8;
    // ==========================================================
    // controller byte stages and bit quarters
    localparam logic [1:0] S_DEVW = 2'h0;
    localparam logic [1:0] S_WORD = 2'h1;
    localparam logic [1:0] S_DATA = 2'h2;
    localparam logic [1:0] S_DEVR = 2'h3;
    localparam logic [1:0] Q_SET  = 2'h0;
    localparam logic [1:0] Q_RISE = 2'h1;
    localparam logic [1:0] Q_MID  = 2'h2;
    localparam logic [1:0] Q_FALL = 2'h3;
    // ==========================================================
    // state types
    typedef enum logic [4:0] {
        D_IDLE = 5'h01,
        D_ADDR = 5'h02,
        D_WORD = 5'h04,
        D_DATA = 5'h08,
        D_READ = 5'h10
    } see_dst_e;
    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_START = 5'h02,
        H_WBYTE = 5'h04,
        H_RBYTE = 5'h08,
        H_STOP  = 5'h10
    } see_hst_e;
endpackage : see_pkg

// *** see_link_if.sv ***
`timescale 1ns/1ps
interface see_link_if;
    logic scl;
    logic sda;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_host_o;
    logic sda_host_oe;
    // ==========================================================
    // open-drain wire: low when any driver pulls low
    assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));
    modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface : see_link_if

// *** see_dev.sv ***
`timescale 1ns/1ps
module see_dev
    import see_pkg::*;
#(
    parameter int AW  = ADDR_W,
    parameter int INTERNAL_WRITE_CYCLE_TIME = TWR_CYC
) (
    see_link_if.dev lnk,
    input  logic    clock,
    input  logic    sys_rst,
    output logic    wr_busy
);
    localparam int DEPTH = 1 << AW;
    localparam int CW    = $clog2(INTERNAL_WRITE_CYCLE_TIME + 1);

    logic [7:0]    mem [DEPTH];

    logic          start_tog_ff;
    logic          stop_tog_ff;

    logic          start_seen_ff;
    see_dst_e      st_ff;
    logic [3:0]    bc_ff;
    logic [6:0]    sh_ff;
    logic [AW-1:0] addr_ff;
    logic [2:0]    page_ff;
    logic          ack_ff;
    logic          wr_tog_ff;
    logic          busy_s1_ff;
    logic          busy_s2_ff;
    logic          drv_ff;

    logic          stop_s1_ff;
    logic          stop_s2_ff;
    logic          stop_s3_ff;
    logic          wr_s1_ff;
    logic          wr_s2_ff;
    logic          wr_done_ff;
    logic          busy_ff;
    logic [CW-1:0] cnt_ff;

    logic          start_pend;
    logic [7:0]    rx_byte;
    logic          last_bit;
    logic          in_ack;
    logic          type_ok;
    logic          page_ok;
    logic          match;
    logic [AW-1:0] addr_inc;
    logic [AW-1:0] addr_page;
    logic [AW-1:0] addr_load;
    logic          rd_bit;
    logic          mem_we;
    logic          nxt_drv;
    logic          stop_evt;
    logic          wr_new;

    // ==========================================================
    // start and stop seen on data edges while clock is high
    always_ff @(negedge lnk.sda or posedge sys_rst) begin
        if (sys_rst) begin
            start_tog_ff <= 1'b0;
        end else if (lnk.scl) begin
            start_tog_ff <= ~start_tog_ff;
        end
    end

    always_ff @(posedge lnk.sda or posedge sys_rst) begin
        if (sys_rst) begin
            stop_tog_ff <= 1'b0;
        end else if (lnk.scl) begin
            stop_tog_ff <= ~stop_tog_ff;
        end
    end

    // ==========================================================
    // decode
    assign start_pend = start_tog_ff ^ start_seen_ff;
    assign rx_byte    = {sh_ff, lnk.sda};
    assign last_bit   = (bc_ff == BC_LAST);
    assign in_ack     = (bc_ff == BC_ACK);
    assign type_ok    = (rx_byte[7:4] == DEV_TYPE);
    assign page_ok    = ((rx_byte[3:1] >> (AW - 8)) == 3'h0);
    assign match      = type_ok & page_ok & ~busy_s2_ff;
    assign addr_inc   = addr_ff + 1'b1;
    assign addr_page  = {addr_ff[AW-1:PAGE_LSB_W], addr_ff[PAGE_LSB_W-1:0] + 1'b1};
    assign addr_load  = AW'({page_ff, rx_byte});
    assign rd_bit     = mem[addr_ff][~bc_ff[2:0]];
    assign mem_we     = ~start_pend & (st_ff == D_DATA) & last_bit;

    // ==========================================================
    // link side: bits taken on rising clock
    always_ff @(posedge lnk.scl) begin
        if (mem_we) begin
            mem[addr_ff] <= rx_byte;
        end
    end

    always_ff @(posedge lnk.scl or posedge sys_rst) begin
        if (sys_rst) begin
            start_seen_ff <= 1'b0;
            st_ff         <= D_IDLE;
            bc_ff         <= 4'h0;
            sh_ff         <= 7'h00;
            addr_ff       <= '0;
            page_ff       <= 3'h0;
            ack_ff        <= 1'b0;
            wr_tog_ff     <= 1'b0;
            busy_s1_ff    <= 1'b0;
            busy_s2_ff    <= 1'b0;
        end else begin
            busy_s1_ff <= busy_ff;
            busy_s2_ff <= busy_s1_ff;
            if (start_pend) begin
                start_seen_ff <= start_tog_ff;
                st_ff         <= D_ADDR;
                bc_ff         <= 4'h1;
                sh_ff         <= {6'h00, lnk.sda};
                ack_ff        <= 1'b0;
            end else if (in_ack && ack_ff) begin
                bc_ff  <= 4'h0;
                ack_ff <= 1'b0;
            end else begin
                unique case (st_ff)
                    D_IDLE: begin
                        bc_ff <= 4'h0;
                    end
                    D_ADDR: begin
                        sh_ff <= rx_byte[6:0];
                        bc_ff <= bc_ff + 1'b1;
                        if (last_bit) begin
                            page_ff <= rx_byte[3:1];
                            ack_ff  <= match;
                            if (!match) begin
                                st_ff <= D_IDLE;
                            end else if (rx_byte[0]) begin
                                st_ff <= D_READ;
                            end else begin
                                st_ff <= D_WORD;
                            end
                        end
                    end
                    D_WORD: begin
                        sh_ff <= rx_byte[6:0];
                        bc_ff <= bc_ff + 1'b1;
                        if (last_bit) begin
                            addr_ff <= addr_load;
                            ack_ff  <= 1'b1;
                            st_ff   <= D_DATA;
                        end
                    end
                    D_DATA: begin
                        sh_ff <= rx_byte[6:0];
                        bc_ff <= bc_ff + 1'b1;
                        if (last_bit) begin
                            addr_ff   <= addr_page;
                            wr_tog_ff <= ~wr_tog_ff;
                            ack_ff    <= 1'b1;
                        end
                    end
                    D_READ: begin
                        if (!in_ack) begin
                            bc_ff <= bc_ff + 1'b1;
                        end else begin
                            addr_ff <= addr_inc;
                            bc_ff   <= 4'h0;
                            if (lnk.sda) begin
                                st_ff <= D_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // link side: data changes after falling clock
    assign nxt_drv = start_pend ? 1'b0 :
                     (in_ack && ack_ff) ? 1'b1 :
                     (st_ff == D_READ && !in_ack) ? ~rd_bit :
                     1'b0;

    always_ff @(negedge lnk.scl or posedge sys_rst) begin
        if (sys_rst) begin
            drv_ff <= 1'b0;
        end else begin
            drv_ff <= nxt_drv;
        end
    end

    assign lnk.sda_dev_o  = 1'b0;
    assign lnk.sda_dev_oe = drv_ff;

    // ==========================================================
    // write cycle timer on the system clock
    assign stop_evt = stop_s2_ff ^ stop_s3_ff;
    assign wr_new   = wr_s2_ff ^ wr_done_ff;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stop_s1_ff <= 1'b0;
            stop_s2_ff <= 1'b0;
            stop_s3_ff <= 1'b0;
            wr_s1_ff   <= 1'b0;
            wr_s2_ff   <= 1'b0;
            wr_done_ff <= 1'b0;
            busy_ff    <= 1'b0;
            cnt_ff     <= '0;
        end else begin
            stop_s1_ff <= stop_tog_ff;
            stop_s2_ff <= stop_s1_ff;
            stop_s3_ff <= stop_s2_ff;
            wr_s1_ff   <= wr_tog_ff;
            wr_s2_ff   <= wr_s1_ff;
            if (stop_evt && wr_new) begin
                busy_ff    <= 1'b1;
                cnt_ff     <= CW'(INTERNAL_WRITE_CYCLE_TIME - 1);
                wr_done_ff <= wr_s2_ff;
            end else if (busy_ff) begin
                if (cnt_ff == '0) begin
                    busy_ff <= 1'b0;
                end else begin
                    cnt_ff <= cnt_ff - 1'b1;
                end
            end
        end
    end

    assign wr_busy = busy_ff;
endmodule : see_dev

// *** see_link_assertions.sv ***
`timescale 1ns/1ps
module see_link_assertions
    import see_pkg::*;
#(
    parameter int INTERNAL_WRITE_CYCLE_TIME = TWR_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic wr_busy
);
    // ==========================================================
    // link event decode
    logic       scl_ff;
    logic       sda_ff;
    logic       first_ff;
    logic [3:0] bit_ff;
    logic [7:0] addr_ff;
    int         busy_ff;
    logic       busy_r1_ff;
    logic       busy_r2_ff;
    wire        rise_w  = scl & ~scl_ff;
    wire        start_w = scl & scl_ff & sda_ff & ~sda;
    wire        stop_w  = scl & scl_ff & ~sda_ff & sda;
    wire        ack_w   = rise_w & first_ff & (bit_ff == 4'h8);
    wire        match_w = (addr_ff[7:4] == DEV_TYPE) & ~busy_r2_ff;

    always_ff @(posedge clock) begin
        scl_ff  <= sys_rst | scl;
        sda_ff  <= sys_rst | sda;
        busy_ff <= (wr_busy & ~sys_rst) ? busy_ff + 1 : 0;
        // busy as the device sees it, two link clocks before the ack
        if (rise_w) begin
            busy_r1_ff <= wr_busy;
            busy_r2_ff <= busy_r1_ff;
        end
        if (sys_rst | start_w) begin
            bit_ff   <= 4'h0;
            first_ff <= ~sys_rst;
        end else if (rise_w) begin
            bit_ff   <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
            first_ff <= first_ff & (bit_ff != 4'h8);
            addr_ff  <= (bit_ff < 4'h8) ? {addr_ff[6:0], sda} : addr_ff;
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    odrain_low_a:
        assert property (!sda_dev_o && !sda_host_o) else $error("data driver not open drain");
    dev_hold_a:
        assert property (scl && $past(scl) |-> $stable(sda_dev_oe)) else $error("device data moved with clock high");
    addr_ack_a:
        assert property (ack_w |-> sda_dev_oe == match_w) else $error("address acknowledge wrong");
    busy_quiet_a:
        assert property (wr_busy |-> !sda_dev_oe) else $error("device drove data while busy");
    stop_release_a:
        assert property (stop_w |=> (!sda_dev_oe) [*8]) else $error("device drove data after stop");
    busy_len_a:
        assert property ($fell(wr_busy) |-> busy_ff >= INTERNAL_WRITE_CYCLE_TIME - 3 && busy_ff <= INTERNAL_WRITE_CYCLE_TIME + 3) else $error("write cycle length");
    busy_bound_a:
        assert property (wr_busy |-> busy_ff <= INTERNAL_WRITE_CYCLE_TIME + 3) else $error("write cycle overran");
    clock_high_a:
        assert property ($rose(scl) |-> scl [*8]) else $error("link clock high phase short");

    cover property (ack_w && addr_ff[0] && sda_dev_oe);
    cover property (ack_w && wr_busy);
    cover property (rise_w && !first_ff && bit_ff == 4'h8 && sda_host_oe);
    cover property ($fell(wr_busy));
endmodule : see_link_assertions

// *** tb_serial_eeprom_read_addressing.sv ***
`timescale 1ns/1ps
module tb_serial_eeprom_read_addressing import see_pkg::*;;
    localparam int TWR_SIM = 200;
    logic              clock     = 1'b0;
    logic              sys_rst   = 1'b0;
    logic              req_valid = 1'b0;
    logic              req_read  = 1'b0;
    logic              rd_ready  = 1'b0;
    logic              stall     = 1'b0;
    logic [ADDR_W-1:0] req_addr  = '0;
    logic [7:0]        req_len   = 8'h0;
    logic [7:0]        req_wdata = 8'h0;
    logic              wr_busy, req_ready, done, nack_err, rd_valid;
    logic [7:0]        rd_data;
    logic [7:0]        mem [0:2047];
    logic [7:0]        byte_q [$];
    logic              nack_q [$];
    logic [10:0]       ra;
    int                fails = 0, n_compared = 0, n_done = 0, k;

    always #5 clock = ~clock;

    see_link_if lnk_if ();
    see_dev #(.INTERNAL_WRITE_CYCLE_TIME(TWR_SIM)) i_see_dev (.lnk(lnk_if), .clock(clock), .sys_rst(sys_rst), .wr_busy(wr_busy));
    see_host #(.QTR(5)) i_see_host (.clock(clock), .sys_rst(sys_rst), .lnk(lnk_if), .req_valid(req_valid),
        .req_ready(req_ready), .req_read(req_read), .req_addr(req_addr), .req_len(req_len),
        .req_wdata(req_wdata), .done(done), .nack_err(nack_err), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data));
    see_link_assertions #(.INTERNAL_WRITE_CYCLE_TIME(TWR_SIM)) i_see_link_assertions (.clock(clock), .sys_rst(sys_rst),
        .scl(lnk_if.scl), .sda(lnk_if.sda), .sda_dev_o(lnk_if.sda_dev_o), .sda_dev_oe(lnk_if.sda_dev_oe),
        .sda_host_o(lnk_if.sda_host_o), .sda_host_oe(lnk_if.sda_host_oe), .wr_busy(wr_busy));

    // ==========================================================
    // comparison and verdict
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic complete_run();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // output watcher: transfer happens at the coming rising edge
    always @(negedge clock) begin
        #1;
        if (!sys_rst && rd_valid && rd_ready) check("rd_data", byte_q.pop_front(), rd_data);
        if (!sys_rst && done) begin
            n_done++;
            check("nack_err", {7'h0, nack_q.pop_front()}, {7'h0, nack_err});
        end
    end

    always @(negedge clock) rd_ready <= !stall && ($urandom_range(3) != 0);

    // ==========================================================
    // request driver
    task automatic xfer(logic rd, logic [10:0] a, logic [7:0] n, logic [7:0] d, logic nk);
        int k0;
        k0 = n_done;
        nack_q.push_back(nk);
        for (int i = 0; i < (rd ? n : 0); i++) byte_q.push_back(mem[11'(a + i)]);
        if (!rd && !nk) mem[a] = d;
        @(negedge clock);
        while (!req_ready) @(negedge clock);
        {req_valid, req_read, req_addr, req_len, req_wdata} = {1'b1, rd, a, n, d};
        @(negedge clock);
        req_valid = 1'b0;
        for (int t = 0; t < 30000 && n_done == k0; t++) @(negedge clock);
        if (n_done == k0) begin
            fails++;
            $display("BAD xfer_done expected %0d seen %0d", k0 + 1, n_done);
        end
    endtask : xfer

    task automatic settle();
        repeat (8) @(negedge clock);
        for (int t = 0; t < 1000 && wr_busy; t++) @(negedge clock);
        if (wr_busy) begin
            fails++;
            $display("BAD wr_busy expected 0 seen 1");
        end
    endtask : settle

    // ==========================================================
    // scenarios
    initial begin
        void'($urandom(40));
        // a real reset edge reaches the link-side asynchronous resets
        #1 sys_rst = 1'b1;
        repeat (10) @(negedge clock);
        sys_rst = 1'b0;
        for (int i = 0; i < 10; i++) begin
            xfer(1'b0, 11'(11'h7F9 + i), 8'h1, 8'($urandom), 1'b0);
            settle();
        end
        ra = 11'($urandom);
        xfer(1'b0, ra, 8'h1, 8'($urandom), 1'b0);
        xfer(1'b0, ra, 8'h1, 8'h5A, 1'b1);
        settle();
        xfer(1'b1, ra, 8'h1, 8'h0, 1'b0);
        xfer(1'b1, 11'h7FF, 8'h3, 8'h0, 1'b0);
        stall = 1'b1;
        k = n_done;
        fork
            xfer(1'b1, 11'h7F9, 8'hA, 8'h0, 1'b0);
        join_none
        repeat (3000) @(negedge clock);
        check("stalled_done", 8'(k), 8'(n_done));
        stall = 1'b0;
        wait fork;
        repeat (400) @(negedge clock);
        check("left_bytes", 8'h0, 8'(byte_q.size()));
        complete_run();
    end

    initial begin
        repeat (60000) @(negedge clock);
        fails++;
        complete_run();
    end
endmodule : tb_serial_eeprom_read_addressing
